// File: include/jsu_pkg.sv
// jsu_pkg: constants, types and shared functions of the jtag secure unlock gate
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package jsu_pkg;

  // code storage
  localparam int          KEY_W         = 128;
  localparam logic [31:0] OTP_CODE_ADDR = 32'hf000_0000;
  localparam logic [127:0] OTP_DELIVERED = 128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff;
  localparam logic [127:0] KEY_RESET     = 128'h0;
  // hidden tie-offs, arbitrary values
  localparam logic [127:0] HIDDEN_TIEOFF = 128'h3c5a_96e1_0f78_a52d_c3b4_691e_d287_4b1f;
  // reference chosen so the delivered code with a cleared key matches
  localparam logic [127:0] HIDDEN_REF    = OTP_DELIVERED ^ KEY_RESET ^ HIDDEN_TIEOFF;

  // instruction register
  localparam int         IR_W        = 4;
  localparam logic [3:0] IR_EXTEST   = 4'h0;
  localparam logic [3:0] IR_SAMPLE   = 4'h1;
  localparam logic [3:0] IR_SEC_TAP0 = 4'h4;
  localparam logic [3:0] IR_KEY_TAP  = 4'h6;
  localparam logic [3:0] IR_TEST_TAP = 4'h8;
  localparam logic [3:0] IR_BYPASS   = 4'hf;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [3:0] IR_RESET    = IR_BYPASS;

  // tap router
  localparam int         SEC_TAPS    = 4;
  localparam logic [1:0] KEY_TAP_NUM = 2'h2;
  localparam int         BSC_LEN     = 8;

  // tap controller states
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001, ST_RTI   = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } jsu_tap_state_t;

  // data register routes
  typedef enum logic [4:0] {
    RT_BYPASS = 5'h01, RT_BOUNDARY = 5'h02, RT_KEY = 5'h04, RT_SEC = 5'h08, RT_TEST = 5'h10
  } jsu_route_t;

  // unlock comparison over code, key and hidden constants
  function automatic logic unlock_match(input logic [127:0] code, input logic [127:0] key);
    logic [127:0] mixed;
    mixed = code ^ key;
    return (code != 128'h0) && ((mixed ^ HIDDEN_TIEOFF) == HIDDEN_REF);
  endfunction : unlock_match

  // standard tap controller transitions
  function automatic jsu_tap_state_t tap_next(input jsu_tap_state_t st, input logic tms);
    jsu_tap_state_t nx;
    nx = ST_TLR;
    case (st)
      ST_TLR:    nx = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    nx = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nx = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nx = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nx = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  nx = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nx = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nx = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nx = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nx = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nx = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  nx = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nx = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nx = tms ? ST_SEL_DR : ST_RTI;
      default:   nx = ST_TLR;
    endcase
    return nx;
  endfunction : tap_next

endpackage : jsu_pkg

// File: logic/jsu_otp_mem.sv
// jsu_otp_mem: one-time-programmable store of the visible unlock code
`timescale 1ns/100ps
module jsu_otp_mem
  import jsu_pkg::*;
#(
  parameter int           W    = KEY_W,
  parameter logic [127:0] INIT = OTP_DELIVERED
) (
  // clock
  input  wire logic         sys_clk,
  // programming port
  input  wire logic         prog_en,
  input  wire logic [31:0]  prog_addr,
  input  wire logic [W-1:0] prog_data,
  // registered read data
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] cells = INIT[W-1:0];   // nonvolatile: no reset may touch it
  logic [W-1:0] next_cells;

  //////////////////////////////////////////////////////////////////////////////
  // programming only clears bits; a one written where a zero is stays zero
  always_comb begin
    next_cells = cells;
    if (prog_en && (prog_addr == OTP_CODE_ADDR)) begin
      next_cells = cells & prog_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    cells   <= next_cells;
    rd_data <= cells;
  end

endmodule : jsu_otp_mem

// File: logic/jsu_secure_gate.sv
// jsu_secure_gate: jtag tap router with scan-key unlock gating
`timescale 1ns/100ps
module jsu_secure_gate
  import jsu_pkg::*;
#(
  parameter int BSC_N = BSC_LEN
) (
  // system clock and resets
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                poweron_reset_low,
  // jtag link
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  // otp programming
  input  wire logic                otp_prog_en,
  input  wire logic [31:0]         otp_prog_addr,
  input  wire logic [KEY_W-1:0]    otp_prog_data,
  // unlock status
  output logic                     access_granted,
  // secondary and test taps
  output logic [SEC_TAPS-1:0]      sec_tap_en,
  input  wire logic [SEC_TAPS-1:0] sec_tap_tdo,
  output logic                     test_tap_en,
  input  wire logic                test_tap_tdo,
  // boundary cells
  input  wire logic [BSC_N-1:0]    bsc_pin_in,
  output logic [BSC_N-1:0]         bsc_pin_out,
  output logic                     bsc_out_en
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [KEY_W-1:0]  otp_code;
  // tck side
  jsu_tap_state_t    state, next_state;
  logic [IR_W-1:0]   ir, next_ir;
  logic [IR_W-1:0]   ir_shift, next_ir_shift;
  logic              bypass, next_bypass;
  logic [BSC_N-1:0]  bsc_shift, next_bsc_shift;
  logic [BSC_N-1:0]  bsc_upd, next_bsc_upd;
  logic [KEY_W-1:0]  key, next_key;
  logic [KEY_W-1:0]  key_shift, next_key_shift;
  logic              key_tgl, next_key_tgl;
  logic              sec_s1, sec_s2, sec_s3, secured_tck, next_secured_tck;
  logic [BSC_N-1:0]  pin_s1, pin_s2, pin_s3, pin_q, next_pin_q;
  logic [SEC_TAPS-1:0] next_sec_tap_en;
  logic              next_test_tap_en, next_bsc_out_en;
  logic              next_tdo, next_tdo_oe;
  jsu_route_t        route;
  logic [1:0]        sec_idx;
  logic              dr_serial;
  // sys side
  logic              tgl_s1, tgl_s2, tgl_s3, tgl_seen, next_tgl_seen;
  logic              key_capture;
  logic [KEY_W-1:0]  key_sys, next_key_sys;
  logic              next_access_granted;

  //////////////////////////////////////////////////////////////////////////////
  // code storage
  jsu_otp_mem #(
    .W    (KEY_W),
    .INIT (OTP_DELIVERED)
  ) u_otp (
    .sys_clk   (sys_clk),
    .prog_en   (otp_prog_en),
    .prog_addr (otp_prog_addr),
    .prog_data (otp_prog_data),
    .rd_data   (otp_code)
  );

  //////////////////////////////////////////////////////////////////////////////
  // route decode: a secured part falls back to bypass for any blocked path
  function automatic jsu_route_t route_of(input logic [IR_W-1:0] code, input logic secured);
    jsu_route_t rt;
    rt = RT_BYPASS;
    if (code == IR_KEY_TAP) begin
      rt = RT_KEY;
    end else if (secured) begin
      rt = RT_BYPASS;
    end else if ((code == IR_EXTEST) || (code == IR_SAMPLE)) begin
      rt = RT_BOUNDARY;
    end else if ((code >= IR_SEC_TAP0) && (code < IR_SEC_TAP0 + 4'h4)) begin
      rt = RT_SEC;
    end else if (code == IR_TEST_TAP) begin
      rt = RT_TEST;
    end
    return rt;
  endfunction : route_of

  assign route   = route_of(ir, secured_tck);
  assign sec_idx = 2'(ir - IR_SEC_TAP0);

  //////////////////////////////////////////////////////////////////////////////
  // serial output of the selected data path
  always_comb begin
    dr_serial = bypass;
    case (route)
      RT_BOUNDARY: dr_serial = bsc_shift[0];
      RT_KEY:      dr_serial = key_shift[0];
      RT_SEC:      dr_serial = sec_tap_tdo[sec_idx];
      RT_TEST:     dr_serial = test_tap_tdo;
      default:     dr_serial = bypass;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // tap controller and data registers, next values
  always_comb begin
    next_state     = tap_next(state, tms);
    next_ir        = ir;
    next_ir_shift  = ir_shift;
    next_bypass    = bypass;
    next_bsc_shift = bsc_shift;
    next_bsc_upd   = bsc_upd;
    next_key       = key;
    next_key_shift = key_shift;
    next_key_tgl   = key_tgl;
    case (state)
      ST_TLR: begin
        next_ir = IR_RESET;
      end
      ST_CAP_IR: begin
        next_ir_shift = IR_CAPTURE;
      end
      ST_SH_IR: begin
        next_ir_shift = {tdi, ir_shift[IR_W-1:1]};
      end
      ST_UPD_IR: begin
        next_ir = ir_shift;
      end
      ST_CAP_DR: begin
        if (route == RT_BYPASS) begin
          next_bypass = 1'b0;
        end else if (route == RT_BOUNDARY) begin
          next_bsc_shift = pin_q;
        end else if (route == RT_KEY) begin
          // only the lock state is read back, never the key itself
          next_key_shift = {{(KEY_W-1){1'b0}}, ~secured_tck};
        end
      end
      ST_SH_DR: begin
        if (route == RT_BYPASS) begin
          next_bypass = tdi;
        end else if (route == RT_BOUNDARY) begin
          next_bsc_shift = {tdi, bsc_shift[BSC_N-1:1]};
        end else if (route == RT_KEY) begin
          next_key_shift = {tdi, key_shift[KEY_W-1:1]};
        end
      end
      ST_UPD_DR: begin
        if (route == RT_BOUNDARY) begin
          next_bsc_upd = bsc_shift;
        end else if (route == RT_KEY) begin
          next_key     = key_shift;
          next_key_tgl = ~key_tgl;  // tells the system side a new key stands
        end
      end
      default: begin
        next_ir = ir;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // path enables, gated by the synchronised lock state except the key tap enable, which follows the key route
  always_comb begin
    next_sec_tap_en = '0;
    if (route == RT_SEC) begin
      next_sec_tap_en[sec_idx] = 1'b1;
    end
    next_sec_tap_en[KEY_TAP_NUM] = (route == RT_KEY);
    next_test_tap_en = (route == RT_TEST);
    next_bsc_out_en  = (route == RT_BOUNDARY) && (ir == IR_EXTEST);
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock state and pin inputs into tck: three flops, change taken when 2 and 3 agree
  always_comb begin
    next_secured_tck = (sec_s2 == sec_s3) ? sec_s3 : secured_tck;
    next_pin_q       = (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
  end

  //////////////////////////////////////////////////////////////////////////////
  // tdo changes on the falling edge so the tester samples a settled bit
  always_comb begin
    next_tdo    = 1'b0;
    next_tdo_oe = 1'b0;
    if (state == ST_SH_IR) begin
      next_tdo    = ir_shift[0];
      next_tdo_oe = 1'b1;
    end else if (state == ST_SH_DR) begin
      next_tdo    = dr_serial;
      next_tdo_oe = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tck domain registers on the ordinary reset
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      state       <= ST_TLR;
      ir          <= IR_RESET;
      ir_shift    <= IR_RESET;
      bypass      <= 1'b0;
      bsc_shift   <= '0;
      bsc_upd     <= '0;
      key_tgl     <= 1'b0;
      sec_s1      <= 1'b1;
      sec_s2      <= 1'b1;
      sec_s3      <= 1'b1;
      secured_tck <= 1'b1;  // start locked until the system side says otherwise
      pin_s1      <= '0;
      pin_s2      <= '0;
      pin_s3      <= '0;
      pin_q       <= '0;
      sec_tap_en  <= '0;
      test_tap_en <= 1'b0;
      bsc_out_en  <= 1'b0;
      bsc_pin_out <= '0;
    end else begin
      state       <= next_state;
      ir          <= next_ir;
      ir_shift    <= next_ir_shift;
      bypass      <= next_bypass;
      bsc_shift   <= next_bsc_shift;
      bsc_upd     <= next_bsc_upd;
      key_tgl     <= next_key_tgl;
      sec_s1      <= ~access_granted;
      sec_s2      <= sec_s1;
      sec_s3      <= sec_s2;
      secured_tck <= next_secured_tck;
      pin_s1      <= bsc_pin_in;
      pin_s2      <= pin_s1;
      pin_s3      <= pin_s2;
      pin_q       <= next_pin_q;
      sec_tap_en  <= next_sec_tap_en;
      test_tap_en <= next_test_tap_en;
      bsc_out_en  <= next_bsc_out_en;
      bsc_pin_out <= next_bsc_upd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // key register and its shift stage survive every reset but power-on
  always_ff @(posedge tck or negedge poweron_reset_low) begin
    if (!poweron_reset_low) begin
      key       <= KEY_RESET;
      key_shift <= KEY_RESET;
    end else begin
      key       <= next_key;
      key_shift <= next_key_shift;
    end
  end

  // falling-edge output stage
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system side: take the key word once its toggle has settled
  always_comb begin
    next_tgl_seen = (tgl_s2 == tgl_s3) ? tgl_s3 : tgl_seen;
    key_capture   = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen);
    next_key_sys  = key_capture ? key : key_sys;
    // compared every cycle: a reprogrammed code reaches the grant two cycles after the write, a new key one cycle after its capture
    next_access_granted = unlock_match(otp_code, key_sys);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tgl_s1         <= 1'b0;
      tgl_s2         <= 1'b0;
      tgl_s3         <= 1'b0;
      tgl_seen       <= 1'b0;
      access_granted <= 1'b0;
    end else begin
      tgl_s1         <= key_tgl;
      tgl_s2         <= tgl_s1;
      tgl_s3         <= tgl_s2;
      tgl_seen       <= next_tgl_seen;
      access_granted <= next_access_granted;
    end
  end

  // system copy of the key follows the power-on reset only
  always_ff @(posedge sys_clk or negedge poweron_reset_low) begin
    if (!poweron_reset_low) begin
      key_sys <= KEY_RESET;
    end else begin
      key_sys <= next_key_sys;
    end
  end

endmodule : jsu_secure_gate

// File: testbench/jsu_gate_props.sv
// jsu_gate_props: port assertions of the secure unlock gate
`timescale 1ns/100ps
module jsu_gate_props
  import jsu_pkg::*;
#(
  parameter int BSC_N = BSC_LEN
) (
  // clocks and resets
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                tck,
  // observed ports
  input wire logic                tdo,
  input wire logic                tdo_oe,
  input wire logic                otp_prog_en,
  input wire logic [31:0]         otp_prog_addr,
  input wire logic [KEY_W-1:0]    otp_prog_data,
  input wire logic                access_granted,
  input wire logic [SEC_TAPS-1:0] sec_tap_en,
  input wire logic                test_tap_en,
  input wire logic [BSC_N-1:0]    bsc_pin_out,
  input wire logic                bsc_out_en
);
  ////////////////////////////////////////
  // an all-zero code can never be raised again, so the gate stays shut
  sequence zero_write;
    otp_prog_en && otp_prog_addr == OTP_CODE_ADDR && otp_prog_data == '0;
  endsequence
  sequence held_shut;
    !access_granted [*8];
  endsequence
  chk_zero_code: assert property (@(posedge sys_clk) disable iff (rst) zero_write |-> ##3 held_shut)
    else $error("grant seen after an all-zero code");
  // the store never regains a one, so once zeroed the gate stays shut whatever key arrives later
  logic zeroed = 1'b0;
  always @(posedge sys_clk) begin
    if (otp_prog_en && otp_prog_addr == OTP_CODE_ADDR && otp_prog_data == '0) begin
      zeroed <= 1'b1;
    end
  end
  chk_zero_stays: assert property (@(posedge sys_clk) disable iff (rst) zeroed |-> ##2 !access_granted)
    else $error("grant seen after the code was zeroed");
  // routes other than the key chain only open while unlocked
  chk_tap_gate: assert property (@(posedge tck) disable iff (rst)
    $rose(|(sec_tap_en & 4'hb)) |-> access_granted)
    else $error("secondary tap opened while secured");
  chk_test_gate: assert property (@(posedge tck) disable iff (rst) $rose(test_tap_en) |-> access_granted)
    else $error("test tap opened while secured");
  chk_bsc_gate: assert property (@(posedge tck) disable iff (rst) $rose(bsc_out_en) |-> access_granted)
    else $error("boundary drive enabled while secured");
  chk_bsc_hold: assert property (@(posedge tck) disable iff (rst) $changed(bsc_pin_out) |-> access_granted)
    else $error("boundary update while secured");
  // one route at a time, so a blocked route cannot ride along
  chk_one_route: assert property (@(posedge tck) disable iff (rst)
    $onehot0({sec_tap_en, test_tap_en, bsc_out_en}))
    else $error("two scan routes enabled");
  // reset leaves every route closed and tdo released
  chk_idle_exit: assert property (@(posedge tck) disable iff (rst)
    $fell(rst) |-> {sec_tap_en, test_tap_en, bsc_out_en, tdo_oe} == '0)
    else $error("route open after reset");
  // tdo only moves inside a shift or on the edge leaving it
  chk_tdo_quiet: assert property (@(posedge tck) disable iff (rst)
    $changed(tdo) |-> tdo_oe || $past(tdo_oe))
    else $error("tdo moved outside a shift");
endmodule : jsu_gate_props

bind jsu_secure_gate jsu_gate_props #(.BSC_N(BSC_N)) i_jsu_gate_props (
  .sys_clk(sys_clk), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .otp_prog_en(otp_prog_en),
  .otp_prog_addr(otp_prog_addr), .otp_prog_data(otp_prog_data), .access_granted(access_granted),
  .sec_tap_en(sec_tap_en), .test_tap_en(test_tap_en), .bsc_pin_out(bsc_pin_out), .bsc_out_en(bsc_out_en));

// File: testbench/jsu_jtag_host.sv
// jsu_jtag_host: behavioural debugger on the far side of the jtag link
`timescale 1ns/100ps
module jsu_jtag_host (
  // link driven by the debugger
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // link returned by the device
  input  wire logic tdo
);
  ////////////////////////////////////////
  // tck rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 12 ns period: drive after the fall, take tdo at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #6;
    tck = 1'b1;
    q = tdo;
    #6;
    tck = 1'b0;
  endtask : step
  // walk the controller, tms bits lsb first; idle tdi toggles so it never looks held
  task automatic moves(input logic [3:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(pat[i], i[0], q);
    end
  endtask : moves
  // ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [127:0] d, output logic [127:0] cap);
    logic q;
    cap = '0;
    moves(ir ? 4'h3 : 4'h1, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], q);
      cap[i] = q;
    end
    moves(4'h1, 2);
  endtask : scan
endmodule : jsu_jtag_host

// File: testbench/jsu_secure_gate_test.sv
// jsu_secure_gate_test: self-checking bench of the secure unlock gate
`timescale 1ns/100ps
module jsu_secure_gate_test
  import jsu_pkg::*;
;
  // design ports
  logic         sys_clk, rst, poweron_reset_low, tck, tms, tdi, tdo, tdo_oe;
  logic         otp_prog_en, access_granted, test_tap_en, test_tap_tdo, bsc_out_en;
  logic [31:0]  otp_prog_addr;
  logic [127:0] otp_prog_data;
  logic [3:0]   sec_tap_en, sec_tap_tdo;
  logic [7:0]   bsc_pin_in, bsc_pin_out, d0, d1;
  // bench state
  int           failures = 0;
  int           comparisons = 0;
  int           cycles = 0;
  logic [31:0]  seed = 32'h0000_0037;
  logic [127:0] code, cap;
  string        name_q[$];
  logic [127:0] exp_q[$], seen_q[$];
  localparam logic [3:0] CODES [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};

  jsu_secure_gate #(.BSC_N(8)) i_jsu_secure_gate (
    .sys_clk(sys_clk), .rst(rst), .poweron_reset_low(poweron_reset_low), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .otp_prog_en(otp_prog_en), .otp_prog_addr(otp_prog_addr),
    .otp_prog_data(otp_prog_data), .access_granted(access_granted), .sec_tap_en(sec_tap_en),
    .sec_tap_tdo(sec_tap_tdo), .test_tap_en(test_tap_en), .test_tap_tdo(test_tap_tdo),
    .bsc_pin_in(bsc_pin_in), .bsc_pin_out(bsc_pin_out), .bsc_out_en(bsc_out_en));
  jsu_jtag_host i_jsu_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  ////////////////////////////////////////
  // system clock, 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard, far above the length of the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  // watcher: oldest note against each result as it appears
  initial forever begin
    @(posedge sys_clk);
    while (seen_q.size() > 0) begin
      compare(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
    end
  end
  task automatic compare(input string nm, input logic [127:0] s, input logic [127:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : compare
  task automatic note(input string nm, input logic [127:0] e, input logic [127:0] s);
    name_q.push_back(nm);
    exp_q.push_back(e);
    seen_q.push_back(s);
  endtask : note
  task automatic test_done();
    // let the watcher drain the last notes first
    @(posedge sys_clk);
    #1;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // routes an instruction may open: {secondary taps, test tap, boundary drive}
  function automatic logic [5:0] en_exp(input logic [3:0] c, input logic open);
    if (c == IR_EXTEST) return {5'h00, open};
    if (c == IR_TEST_TAP) return {4'h0, open, 1'b0};
    if (c[3:2] == 2'h1 && (open || c == IR_KEY_TAP)) return {4'h1 << c[1:0], 2'h0};
    return 6'h00;
  endfunction : en_exp
  task automatic wait_sys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_sys
  task automatic ir(input logic [3:0] c);
    i_jsu_jtag_host.scan(1'b1, 4, 128'(c), cap);
  endtask : ir
  task automatic grant_is(input logic e);
    note("grant", 128'(e), 128'(access_granted));
  endtask : grant_is
  task automatic prog(input logic [31:0] a, input logic [127:0] d);
    @(negedge sys_clk);
    otp_prog_addr = a;
    otp_prog_data = d;
    otp_prog_en = 1'b1;
    @(negedge sys_clk);
    otp_prog_en = 1'b0;
  endtask : prog
  // every instruction code against the routes it may open
  task automatic sweep(input logic open);
    for (int i = 0; i < 8; i++) begin
      ir(CODES[i]);
      // enables follow the new instruction one tck later, and tck rests after a scan
      i_jsu_jtag_host.moves(4'h0, 1);
      note("routes", 128'(en_exp(CODES[i], open)), 128'({sec_tap_en, test_tap_en, bsc_out_en}));
    end
  endtask : sweep
  // reset pulse with tck running so the link side sees it too
  task automatic pulse();
    fork
      i_jsu_jtag_host.moves(4'hf, 5);
      wait_sys(3);
    join
    wait_sys(1);
  endtask : pulse

  ////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    poweron_reset_low = 1'b0;
    otp_prog_en = 1'b0;
    otp_prog_addr = OTP_CODE_ADDR;
    otp_prog_data = '1;
    sec_tap_tdo = 4'(rnd());
    test_tap_tdo = 1'(rnd());
    bsc_pin_in = 8'(rnd());
    fork
      i_jsu_jtag_host.moves(4'hf, 4);
      wait_sys(20);
    join
    rst = 1'b0;
    poweron_reset_low = 1'b1;
    i_jsu_jtag_host.moves(4'h0, 1);
    wait_sys(4);
    grant_is(1'b1);
    // boundary chain while open: capture pins, drive update
    d0 = 8'(rnd());
    ir(IR_EXTEST);
    i_jsu_jtag_host.scan(1'b0, 8, 128'(d0), cap);
    note("bsc_capture", 128'(bsc_pin_in), cap);
    note("bsc_update", 128'(d0), 128'(bsc_pin_out));
    // open test tap and secondary tap 1 pass their own tdo straight through
    ir(IR_TEST_TAP);
    i_jsu_jtag_host.scan(1'b0, 8, 128'(d0), cap);
    note("test_tap", 128'({8{test_tap_tdo}}), cap);
    ir(4'h5);
    i_jsu_jtag_host.scan(1'b0, 8, 128'(d0), cap);
    note("sec_tap", 128'({8{sec_tap_tdo[1]}}), cap);
    sweep(1'b1);
    // a write elsewhere leaves the code alone
    prog(32'hf000_0010, '0);
    wait_sys(3);
    grant_is(1'b1);
    code = ~(128'h1 << 7'(rnd()));
    prog(OTP_CODE_ADDR, code);
    wait_sys(3);
    grant_is(1'b0);
    prog(OTP_CODE_ADDR, '1);
    wait_sys(3);
    grant_is(1'b0);
    sweep(1'b0);
    // blocked boundary access falls back to a one-bit bypass
    d1 = 8'(rnd());
    ir(IR_EXTEST);
    i_jsu_jtag_host.scan(1'b0, 8, 128'(d1), cap);
    note("bypass", 128'({d1[6:0], 1'b0}), cap);
    note("bsc_update", 128'(d0), 128'(bsc_pin_out));
    // key restoring the delivered code, through the key chain
    ir(IR_KEY_TAP);
    i_jsu_jtag_host.scan(1'b0, 128, ~code, cap);
    note("key_capture", '0, cap);
    wait_sys(8);
    grant_is(1'b1);
    // plain reset keeps the key, power-on reset clears it
    wait_sys(1);
    rst = 1'b1;
    pulse();
    rst = 1'b0;
    i_jsu_jtag_host.moves(4'h0, 1);
    wait_sys(4);
    grant_is(1'b1);
    poweron_reset_low = 1'b0;
    pulse();
    poweron_reset_low = 1'b1;
    i_jsu_jtag_host.moves(4'h0, 1);
    wait_sys(8);
    grant_is(1'b0);
    // all-zero code stays shut even for a key that would match it
    prog(OTP_CODE_ADDR, '0);
    ir(IR_KEY_TAP);
    i_jsu_jtag_host.scan(1'b0, 128, '1, cap);
    wait_sys(8);
    grant_is(1'b0);
    test_done();
  end
endmodule : jsu_secure_gate_test
